// File: dapo_core.sv
/*
 * dapo_core: digital core of a dual pipelined converter with parallel
 * sample buses, an 8-word capture FIFO and an AHB-Lite register slave.
 * Assumes stage decisions come from comparators clocked by clk, control
 * pins arrive asynchronously, and the tri-state drivers sit outside.
 */
// Overview of operation
// - sample both channels every rising edge
// - result appears exactly five cycles later
// - both buses update together on rising edge
// - nine stages, half-cycle steps, before latch
// - digital correction merges redundant stage results
// - format low offset binary, high two's complement
// - 10-bit code, two's complement flips top bit
// - sleep disables both channels, bias stays
// - power-down holds last output value
// - output enable high three-states both buses
// - output enable low drives both buses
// - bit 9 most significant, bit 0 least
// - sleep and power-down low: normal conversion
`timescale 1ns/10ps

module dapo_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 8,
    parameter int LEVEL_W = $clog2(DEPTH + 1)
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [LEVEL_W-1:0] level
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PTR_W-1:0] wr_q;
    logic [PTR_W-1:0] wr_d;
    logic [PTR_W-1:0] rd_q;
    logic [PTR_W-1:0] rd_d;
    logic [LEVEL_W-1:0] cnt_q;
    logic [LEVEL_W-1:0] cnt_d;
    logic push;
    logic pop;

    // honest full and empty from the occupancy count
    assign in_ready = (cnt_q != LEVEL_W'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    assign level = cnt_q;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // pointer and count next values
    always_comb
    begin
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_d = cnt_q;
        if (push)
        begin
            wr_d = (wr_q == PTR_W'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
        end
        if (pop)
        begin
            rd_d = (rd_q == PTR_W'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
        end
        if (push && !pop)
        begin
            cnt_d = cnt_q + 1'b1;
        end
        else if (pop && !push)
        begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    // pointer and count registers
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // storage array, written on push only
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule

module dapo_core #(
    parameter int FIFO_DEPTH = dapo_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [dapo_pkg::STAGE_N*dapo_pkg::STAGE_CODE_W-1:0] chan_a_stage_codes,
    input wire logic [dapo_pkg::STAGE_N*dapo_pkg::STAGE_CODE_W-1:0] chan_b_stage_codes,
    input wire logic format_select,
    input wire logic sleep_input,
    input wire logic full_powerdown_input,
    input wire logic output_enable_n,
    output logic [dapo_pkg::CODE_W-1:0] channel_a_sample_bus,
    output logic [dapo_pkg::CODE_W-1:0] channel_b_sample_bus,
    output logic sample_bus_oe,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp
);
    localparam int LEVEL_W = $clog2(FIFO_DEPTH + 1);
    localparam int W = dapo_pkg::CODE_W;

    localparam int SN = dapo_pkg::STAGE_N;
    localparam int SW = dapo_pkg::STAGE_CODE_W;
    localparam int LAT_N = dapo_pkg::LATENCY - 1;
    // control pin synchronisers: three flops, change taken when 2 and 3 agree
    dapo_pkg::dapo_ctl_t sync_q [dapo_pkg::SYNC_DEPTH];
    dapo_pkg::dapo_ctl_t sync_d [dapo_pkg::SYNC_DEPTH];
    dapo_pkg::dapo_ctl_t agree;
    dapo_pkg::dapo_ctl_t ctl_q;
    dapo_pkg::dapo_ctl_t ctl_d;
    logic oe_q;
    logic oe_d;
    logic run;
    // converted pairs and register slave state
    logic [W-1:0] code_out [2];
    dapo_pkg::dapo_pair_t pair_now;
    logic take;
    logic pop;
    logic wr_ctrl_q;
    logic wr_ctrl_d;
    logic capture_q;
    logic capture_d;
    logic overflow_q;
    logic overflow_d;
    logic [31:0] hrdata_q;
    logic [31:0] hrdata_d;
    logic fifo_in_ready;
    logic fifo_out_valid;
    dapo_pkg::dapo_pair_t fifo_out;
    logic [LEVEL_W-1:0] fifo_level;

    // correction: weighted sum of redundant decisions, last stage is 2-bit
    function automatic logic [W:0] correct(dapo_pkg::dapo_stages_t raw);
        logic [W:0] acc;
        logic [SW-1:0] dec;
        acc = '0;
        for (int i = 0; i < SN; i++)
        begin
            dec = raw[(SN - 1 - i) * SW +: SW];
            if (i < SN - 1)
            begin
                dec = (dec == 2'h3) ? 2'h2 : dec; // code 3 illegal in a redundant stage
            end
            acc = acc + ((W + 1)'(dec) << (SN - 1 - i));
        end
        return acc;
    endfunction

    // synchroniser shift and agreement next values
    always_comb
    begin
        sync_d[0] = {format_select, sleep_input, full_powerdown_input, output_enable_n};
        for (int k = 1; k < dapo_pkg::SYNC_DEPTH; k++)
        begin
            sync_d[k] = sync_q[k - 1];
        end
        agree = ~(sync_q[dapo_pkg::SYNC_DEPTH - 2] ^ sync_q[dapo_pkg::SYNC_DEPTH - 1]);
        ctl_d = (sync_q[dapo_pkg::SYNC_DEPTH - 1] & agree) | (ctl_q & ~agree);
        oe_d = !ctl_q.oe_n;
    end

    // synchroniser, held control and output enable registers
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            sync_q <= '{default: '0};
            ctl_q <= '0;
            oe_q <= 1'b0;
        end
        else
        begin
            sync_q <= sync_d;
            ctl_q <= ctl_d;
            oe_q <= oe_d;
        end
    end

    // both channels convert only outside sleep and power-down
    assign run = !ctl_q.sleep && !ctl_q.pd;
    assign sample_bus_oe = oe_q;

    // one identical pipeline per channel, advancing together
    generate
        for (genvar ch = 0; ch < 2; ch++)
        begin : g_chan
            dapo_pkg::dapo_stages_t cap_q;
            dapo_pkg::dapo_stages_t cap_d;
            logic [W-1:0] dly_q [LAT_N];
            logic [W-1:0] dly_d [LAT_N];
            logic [W-1:0] out_q;
            logic [W-1:0] out_d;
            logic [W:0] corr;
            assign corr = correct(cap_q);

            // sample, delay line and output latch next values
            always_comb
            begin
                cap_d = cap_q;
                dly_d = dly_q;
                out_d = out_q;
                if (run)
                begin
                    cap_d = (ch == 0) ? chan_a_stage_codes : chan_b_stage_codes;
                    dly_d[0] = (corr > dapo_pkg::CODE_SAT) ? dapo_pkg::CODE_SAT[W-1:0] : corr[W-1:0];
                    for (int j = 1; j < LAT_N; j++)
                    begin
                        dly_d[j] = dly_q[j - 1];
                    end
                    // two's complement is offset binary with the top bit flipped
                    out_d = ctl_q.format ? {~dly_q[LAT_N - 1][W - 1], dly_q[LAT_N - 1][W - 2:0]}
                        : dly_q[LAT_N - 1];
                end
            end

            // pipeline registers, both channels on the same edge
            always_ff @(posedge clk)
            begin
                if (reset)
                begin
                    cap_q <= '0;
                    dly_q <= '{default: dapo_pkg::CODE_RESET};
                    out_q <= dapo_pkg::CODE_RESET;
                end
                else
                begin
                    cap_q <= cap_d;
                    dly_q <= dly_d;
                    out_q <= out_d;
                end
            end
            assign code_out[ch] = out_q;
        end
    endgenerate

    // output buses straight from the latches, bit 9 most significant
    assign channel_a_sample_bus = code_out[0];
    assign channel_b_sample_bus = code_out[1];
    assign pair_now = {code_out[1], code_out[0]};

    // transfer taken in the address phase; a data read pops the buffer
    assign take = hsel && hready && htrans[1];
    assign pop = take && !hwrite && (haddr[7:0] == dapo_pkg::ADDR_DATA);

    // register slave next values
    always_comb
    begin
        wr_ctrl_d = take && hwrite && (haddr[7:0] == dapo_pkg::ADDR_CTRL);
        capture_d = capture_q;
        overflow_d = overflow_q;
        hrdata_d = hrdata_q;
        if (wr_ctrl_q)
        begin
            capture_d = hwdata[dapo_pkg::CTRL_CAPTURE_BIT];
            overflow_d = 1'b0;
        end
        // a word lost in the cycle of a clear still sets the flag
        if (capture_q && !fifo_in_ready)
        begin
            overflow_d = 1'b1;
        end
        if (take && !hwrite)
        begin
            hrdata_d = dapo_pkg::WORD_ZERO;
            case (haddr[7:0])
                dapo_pkg::ADDR_CTRL:
                begin
                    hrdata_d[dapo_pkg::CTRL_CAPTURE_BIT] = capture_q;
                end
                dapo_pkg::ADDR_STATUS:
                begin
                    hrdata_d[dapo_pkg::ST_SLEEP_BIT] = ctl_q.sleep;
                    hrdata_d[dapo_pkg::ST_PD_BIT] = ctl_q.pd;
                    hrdata_d[dapo_pkg::ST_OE_N_BIT] = ctl_q.oe_n;
                    hrdata_d[dapo_pkg::ST_FORMAT_BIT] = ctl_q.format;
                    hrdata_d[dapo_pkg::ST_EMPTY_BIT] = !fifo_out_valid;
                    hrdata_d[dapo_pkg::ST_FULL_BIT] = !fifo_in_ready;
                    hrdata_d[dapo_pkg::ST_OVERFLOW_BIT] = overflow_q;
                    hrdata_d[dapo_pkg::ST_LEVEL_LSB +: LEVEL_W] = fifo_level;
                end
                dapo_pkg::ADDR_DATA:
                begin
                    hrdata_d[dapo_pkg::DATA_VALID_BIT] = fifo_out_valid;
                    hrdata_d[0 +: W] = fifo_out.a;
                    hrdata_d[dapo_pkg::DATA_B_LSB +: W] = fifo_out.b;
                end
                default: hrdata_d = dapo_pkg::WORD_ZERO;
            endcase
        end
    end

    // register slave registers
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            wr_ctrl_q <= 1'b0;
            capture_q <= 1'b0;
            overflow_q <= 1'b0;
            hrdata_q <= dapo_pkg::WORD_ZERO;
        end
        else
        begin
            wr_ctrl_q <= wr_ctrl_d;
            capture_q <= capture_d;
            overflow_q <= overflow_d;
            hrdata_q <= hrdata_d;
        end
    end

    // zero wait states, every answer OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    // capture buffer of output pairs, filled while capture is on
    dapo_fifo #(
        .WIDTH($bits(dapo_pkg::dapo_pair_t)),
        .DEPTH(FIFO_DEPTH),
        .LEVEL_W(LEVEL_W)
    ) i_dapo_fifo (
        .clk(clk),
        .reset(reset),
        .in_valid(capture_q),
        .in_ready(fifo_in_ready),
        .in_data(pair_now),
        .out_valid(fifo_out_valid),
        .out_ready(pop),
        .out_data(fifo_out),
        .level(fifo_level)
    );
endmodule

// File: dapo_pkg.sv
/*
 * dapo_pkg: shared constants and carrier types for the dual converter
 * digital core. Assumes a single 125 MHz clock and an AHB-Lite register bus.
 */
package dapo_pkg;

    // converter geometry
    localparam int CODE_W = 10;
    localparam int STAGE_N = 9;
    localparam int STAGE_CODE_W = 2;
    localparam int LATENCY = 5;
    localparam int SYNC_DEPTH = 3;
    localparam int FIFO_DEPTH = 8;

    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_DATA = 8'h08;

    // control and status fields
    localparam int CTRL_CAPTURE_BIT = 0;
    localparam int ST_SLEEP_BIT = 0;
    localparam int ST_PD_BIT = 1;
    localparam int ST_OE_N_BIT = 2;
    localparam int ST_FORMAT_BIT = 3;
    localparam int ST_EMPTY_BIT = 4;
    localparam int ST_FULL_BIT = 5;
    localparam int ST_OVERFLOW_BIT = 6;
    localparam int ST_LEVEL_LSB = 8;
    localparam int DATA_VALID_BIT = 31;
    localparam int DATA_B_LSB = 16;

    // reset and saturation values
    localparam logic [CODE_W-1:0] CODE_RESET = 10'h000;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [CODE_W:0] CODE_SAT = 11'h3ff;

    // one conversion result per channel
    typedef struct packed {
        logic [CODE_W-1:0] b;
        logic [CODE_W-1:0] a;
    } dapo_pair_t;

    // raw stage decisions of one channel, stage 0 in the top bits
    typedef logic [STAGE_N*STAGE_CODE_W-1:0] dapo_stages_t;

    // synchronised control pins
    typedef struct packed {
        logic format;
        logic sleep;
        logic pd;
        logic oe_n;
    } dapo_ctl_t;

endpackage

// File: dapo_core_monitor.sv
/* checker of dapo_core port timing and bus answers.
   assumes binding to every dapo_core instance, one clock domain. */
`timescale 1ns/10ps
module dapo_mon (
    input wire logic clk,
    input wire logic reset,
    input wire logic [17:0] chan_a_stage_codes,
    input wire logic [17:0] chan_b_stage_codes,
    input wire logic format_select,
    input wire logic sleep_input,
    input wire logic full_powerdown_input,
    input wire logic output_enable_n,
    input wire logic [9:0] channel_a_sample_bus,
    input wire logic [9:0] channel_b_sample_bus,
    input wire logic sample_bus_oe,
    input wire logic [1:0] htrans,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // inputs quiet in normal mode for eight cycles
    sequence quiet;
        (!full_powerdown_input && !sleep_input && $stable(format_select)
            && $stable(chan_a_stage_codes) && $stable(chan_b_stage_codes))[*8];
    endsequence
    sequence settled;
        quiet ##1 quiet;
    endsequence
    sequence same;
        (chan_a_stage_codes == chan_b_stage_codes)[*8];
    endsequence
    AST_SETTLE: assert property (settled |=> $stable(channel_a_sample_bus)) else $error("bus moved");
    AST_PAIR: assert property ((quiet ##1 (quiet and same)) |->
        channel_a_sample_bus == channel_b_sample_bus) else $error("pair");
    AST_OE_OFF: assert property (output_enable_n[*6] |-> !sample_bus_oe) else $error("oe off");
    AST_OE_ON: assert property (!output_enable_n[*6] |-> sample_bus_oe) else $error("oe on");
    AST_PD: assert property (full_powerdown_input[*6] |=> $stable(channel_b_sample_bus)) else $error("pd hold");
    AST_SLEEP: assert property (sleep_input[*6] |=> $stable(channel_a_sample_bus)) else $error("sleep");
    AST_OKAY: assert property (hresp == 1'b0) else $error("hresp");
    AST_READY: assert property (htrans[1] && hready |-> ##[0:8] hreadyout) else $error("ready");
endmodule
bind dapo_core dapo_mon i_dapo_mon (.*);

// File: dapo_sink.sv
/* downstream capture of both sample buses on the converter clock.
   assumes oe high while the buses are driven. */
`timescale 1ns/10ps
module dapo_sink (
    input wire logic clk,
    input wire logic oe,
    input wire logic wake,
    input wire logic [9:0] bus_a,
    input wire logic [9:0] bus_b,
    output logic [9:0] got_a,
    output logic [9:0] got_b,
    output logic fresh
);
    logic [2:0] cnt_q = 3'h0;
    assign fresh = cnt_q == 3'h5;
    // both buses on one edge, released lines invert the last captured value each cycle
    always @(posedge clk)
    begin
        got_a <= oe ? bus_a : ~got_a;
        got_b <= oe ? bus_b : ~got_b;
        cnt_q <= wake ? 3'h0 : (fresh ? cnt_q : cnt_q + 3'h1);
    end
endmodule

// File: dual_adc_parallel_output_tb_top.sv
/* self-checking bench of dapo_core with a capture sink.
   assumes AHB-Lite single slave, 125 MHz clock. */
`timescale 1ns/10ps
module dual_adc_parallel_output_tb_top;
    logic clk = 0, reset = 1, format_select = 0, sleep_input = 0, full_powerdown_input = 0;
    logic output_enable_n = 0, hwrite = 0, hsel = 1, sample_bus_oe, hreadyout, hresp, fresh;
    logic [17:0] chan_a_stage_codes = 18'h0_0000, chan_b_stage_codes = 18'h0_0000;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
    logic [9:0] channel_a_sample_bus, channel_b_sample_bus, ga, gb, v;
    wire logic hready = hreadyout;
    int num_errors = 0, compares = 0;
    initial forever #4 clk = ~clk;
    dapo_core i_dapo_core (.*);
    dapo_sink i_dapo_sink (.clk(clk), .oe(sample_bus_oe), .wake(full_powerdown_input),
        .bus_a(channel_a_sample_bus), .bus_b(channel_b_sample_bus), .got_a(ga), .got_b(gb),
        .fresh(fresh));
    task automatic chk(string n, logic [31:0] e, logic [31:0] s);
        compares++;
        if (s !== e)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic ahb(logic w, logic [7:0] ad, logic [31:0] d);
        @(posedge clk);
        htrans <= 2'h2;
        haddr <= {24'h00_0000, ad};
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic conclude;
        if (num_errors == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        #100000;
        num_errors++;
        conclude;
    end
    initial
    begin
        tick(8);
        reset <= 0;
        tick(12);
        // new sample shows exactly five cycles after its edge
        v = channel_a_sample_bus;
        chan_a_stage_codes <= 18'h2_aaaa;
        chan_b_stage_codes <= 18'h2_aaaa;
        tick(5);
        chk("latency_old", v, channel_a_sample_bus);
        tick(1);
        chk("latency_new", 1, channel_a_sample_bus !== v);
        tick(4);
        chk("pair", channel_a_sample_bus, channel_b_sample_bus);
        chk("sink", channel_a_sample_bus, ga);
        // coding flips only the top bit
        v = channel_a_sample_bus;
        format_select <= 1;
        tick(12);
        chk("format", v ^ 10'h200, channel_b_sample_bus);
        format_select <= 0;
        // output enable and its status bit
        output_enable_n <= 1;
        tick(6);
        chk("oe_off", 0, sample_bus_oe);
        ahb(0, dapo_pkg::ADDR_STATUS, 32'h0000_0000);
        chk("status_oe", 1, rd[dapo_pkg::ST_OE_N_BIT]);
        output_enable_n <= 0;
        tick(6);
        chk("oe_on", 1, sample_bus_oe);
        // power-down holds while inputs move
        v = channel_a_sample_bus;
        full_powerdown_input <= 1;
        tick(6);
        chan_a_stage_codes <= 18'h1_5555;
        tick(10);
        chk("pd_hold", v, channel_a_sample_bus);
        full_powerdown_input <= 0;
        tick(12);
        chk("wake", 1, fresh);
        chk("wake_code", 10'h1ff, channel_a_sample_bus);
        // sleep freezes channel A, wake converts again
        v = channel_a_sample_bus;
        sleep_input <= 1;
        tick(6);
        chan_a_stage_codes <= 18'h2_aaaa;
        tick(10);
        chk("sleep_hold", v, channel_a_sample_bus);
        sleep_input <= 0;
        tick(12);
        chk("sleep_wake", 10'h3fe, channel_a_sample_bus);
        // fill the capture buffer, then drain it
        ahb(1, dapo_pkg::ADDR_CTRL, 32'h0000_0001);
        tick(20);
        ahb(0, dapo_pkg::ADDR_STATUS, 32'h0000_0000);
        chk("full", 1, rd[dapo_pkg::ST_FULL_BIT]);
        chk("overflow", 1, rd[dapo_pkg::ST_OVERFLOW_BIT]);
        ahb(1, dapo_pkg::ADDR_CTRL, 32'h0000_0000);
        repeat (8)
        begin
            ahb(0, dapo_pkg::ADDR_DATA, 32'h0000_0000);
            chk("valid", 1, rd[dapo_pkg::DATA_VALID_BIT]);
            chk("data_a", 32'h0000_03fe, rd[9:0]);
            chk("data_b", 32'h0000_03fe, rd[25:16]);
        end
        ahb(0, dapo_pkg::ADDR_DATA, 32'h0000_0000);
        chk("empty", 0, rd[dapo_pkg::DATA_VALID_BIT]);
        ahb(0, 8'h40, 32'h0000_0000);
        chk("unmapped", 0, rd);
        conclude;
    end
endmodule
